// ===== src/fsp_ctrl.sv
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "fsp_regs.svh"
module fsp_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [19:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic low_speed_clock, // async level from clock unit
  input wire logic op_done, // same-clock pulse from array engine
  output logic [2:0] op_kind,
  output logic op_start,
  output logic [20:0] op_address,
  output logic [31:0] op_data,
  output logic cpu_stall
);

  // ==========================================================
  // bus decode
  // ==========================================================
  logic access; // access phase of any transfer
  logic wr; // write takes effect this edge
  logic [17:0] idx; // word index = printed offset
  logic hit; // mapped offset
  assign access = psel & penable;
  // a write lands only at the edge that completes the transfer, so a
  // launch or key value is never taken twice during the wait state
  assign wr = access & pwrite & pready;
  assign idx = paddr[19:2];
  assign hit = (idx[15:0] == `FSP_IDX_ADDR) |
               (idx[15:0] == `FSP_IDX_DATA_LO) |
               (idx[15:0] == `FSP_IDX_DATA_HI) |
               (idx[15:0] == `FSP_IDX_ERASE) |
               (idx[15:0] == `FSP_IDX_UNLOCK) |
               (idx[15:0] == `FSP_IDX_SEGMENT) |
               (idx[15:0] == `FSP_IDX_SELF) |
               (idx[15:0] == `FSP_IDX_STATUS);
  logic in_map;
  assign in_map = hit & (idx[17:16] == 2'h0);

  // per-register write strobes
  logic wr_addr, wr_dlo, wr_dhi, wr_erase, wr_key, wr_seg, wr_self;
  assign wr_addr = wr & in_map & (idx[15:0] == `FSP_IDX_ADDR);
  assign wr_dlo = wr & in_map & (idx[15:0] == `FSP_IDX_DATA_LO);
  assign wr_dhi = wr & in_map & (idx[15:0] == `FSP_IDX_DATA_HI);
  assign wr_erase = wr & in_map & (idx[15:0] == `FSP_IDX_ERASE);
  assign wr_key = wr & in_map & (idx[15:0] == `FSP_IDX_UNLOCK);
  assign wr_seg = wr & in_map & (idx[15:0] == `FSP_IDX_SEGMENT);
  assign wr_self = wr & in_map & (idx[15:0] == `FSP_IDX_SELF);

  // ==========================================================
  // low-speed clock synchroniser
  // ==========================================================
  logic [2:0] lsc_sync_q; // three stages, first read only by second
  logic lsc_q; // filtered level
  // capture the async level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lsc_sync_q <= 3'h0;
    end else begin
      lsc_sync_q <= {lsc_sync_q[1:0], low_speed_clock};
    end
  end
  // a change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lsc_q <= 1'b0;
    end else if (lsc_sync_q[1] == lsc_sync_q[2]) begin
      lsc_q <= lsc_sync_q[2];
    end
  end

  // ==========================================================
  // storage registers
  // ==========================================================
  logic [15:0] data_lo_q, data_hi_q, addr_q;
  logic [4:0] seg_q;
  logic self_en_q;
  logic dbusy_prog_q, dbusy_erase_q; // background busy flags
  logic is_data_area;
  assign is_data_area = (seg_q == `FSP_SEG_DATA_AREA);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_lo_q <= `FSP_RST_DATA;
    end else if (wr_dlo) begin
      if (pstrb[0]) data_lo_q[7:0] <= pwdata[7:0];
      if (pstrb[1]) data_lo_q[15:8] <= pwdata[15:8];
    end
  end
  // third and fourth bytes, ones at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_hi_q <= `FSP_RST_DATA;
    end else if (wr_dhi) begin
      if (pstrb[0]) data_hi_q[7:0] <= pwdata[7:0];
      if (pstrb[1]) data_hi_q[15:8] <= pwdata[15:8];
    end
  end
  // flash address register, byte lanes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= `FSP_RST_ADDR;
    end else if (wr_addr) begin
      if (pstrb[0]) addr_q[7:0] <= pwdata[7:0];
      if (pstrb[1]) addr_q[15:8] <= pwdata[15:8];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_q <= `FSP_RST_SEG;
    end else if (wr_seg && pstrb[0]) begin
      seg_q <= pwdata[4:0];
    end
  end
  // enable stays until software clears it
  // writes dropped while on the low-speed clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      self_en_q <= 1'b0;
    end else if (wr_self && pstrb[0] && !lsc_q) begin
      self_en_q <= pwdata[0];
    end
  end

  // ==========================================================
  // start decode
  // ==========================================================
  fsp_pkg::fsp_key_type key_q;
  logic armed, busy, allowed;
  logic req_code, req_data, req_blk, req_sec, req_any;
  assign armed = (key_q == fsp_pkg::FSP_KEY_ARMED);
  // a running engine refuses new starts, whichever area it works on
  assign busy = cpu_stall | dbusy_prog_q | dbusy_erase_q;
  // enable and arm both needed; busy engine also refuses
  assign allowed = self_en_q & armed & ~busy;
  // code area launches on data high word or high byte
  assign req_code = wr_dhi & pstrb[1] & ~is_data_area;
  // data area launches on data low word or low byte
  assign req_data = wr_dlo & pstrb[0] & is_data_area;
  // 01 block, 10 sector, others nothing
  assign req_blk = wr_erase & pstrb[0] & (pwdata[1:0] == `FSP_ERASE_BLOCK);
  assign req_sec = wr_erase & pstrb[0] & (pwdata[1:0] == `FSP_ERASE_SECTOR);
  assign req_any = req_code | req_data | req_blk | req_sec;
  logic start;
  assign start = req_any & allowed;

  // a refused start leaves the arm untouched for a later try

  // ==========================================================
  // unlock sequence
  // ==========================================================
  // 0xfa then 0xf5 arms
  // other traffic leaves the state alone
  // wrong second value drops back to idle
  // arm cleared on start and reset
  // a new key pair is needed per operation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_q <= fsp_pkg::FSP_KEY_IDLE;
    end else if (start) begin
      key_q <= fsp_pkg::FSP_KEY_IDLE;
    end else if (wr_key && pstrb[0]) begin
      case (key_q)
        fsp_pkg::FSP_KEY_IDLE: begin
          if (pwdata[7:0] == `FSP_KEY_FIRST) key_q <= fsp_pkg::FSP_KEY_HALF;
        end
        fsp_pkg::FSP_KEY_HALF: begin
          // any other value, a repeated first key too, drops the step
          if (pwdata[7:0] == `FSP_KEY_SECOND) begin
            key_q <= fsp_pkg::FSP_KEY_ARMED;
          end else begin
            key_q <= fsp_pkg::FSP_KEY_IDLE;
          end
        end
        fsp_pkg::FSP_KEY_ARMED: begin
          key_q <= fsp_pkg::FSP_KEY_ARMED;
        end
        default: begin
          key_q <= fsp_pkg::FSP_KEY_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // operation issue to the array engine
  // ==========================================================
  // erase target from segment and address high byte
  // code programming aligned to four bytes
  // erased cells read ones, programming only clears
  // bits; that is enforced by the array engine, fed here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_start <= 1'b0;
      op_kind <= fsp_pkg::FSP_OP_NONE;
      op_address <= 21'h0;
      op_data <= 32'hffffffff;
    end else begin
      op_start <= start;
      if (start) begin
        if (req_blk || req_sec) begin
          op_kind <= req_blk ? fsp_pkg::FSP_OP_BLOCK_ERASE :
                     fsp_pkg::FSP_OP_SECTOR_ERASE;
          op_address <= {seg_q, addr_q[15:8], 8'h00};
          op_data <= 32'hffffffff;
        end else if (req_code) begin
          op_kind <= fsp_pkg::FSP_OP_PROG_CODE;
          op_address <= {seg_q, addr_q[15:2], 2'h0};
          op_data <= {(pstrb[1] ? pwdata[15:8] : data_hi_q[15:8]),
                      (pstrb[0] ? pwdata[7:0] : data_hi_q[7:0]),
                      data_lo_q};
        end else begin
          op_kind <= fsp_pkg::FSP_OP_PROG_DATA;
          op_address <= {seg_q, addr_q};
          op_data <= {24'hffffff, pwdata[7:0]};
        end
      end
    end
  end

  // ==========================================================
  // busy tracking
  // ==========================================================
  // set beats clear, so a stray op_done cannot hide a fresh start
  // code operations hold the cpu until done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_stall <= 1'b0;
    end else if (start && !is_data_area) begin
      cpu_stall <= 1'b1;
    end else if (op_done) begin
      cpu_stall <= 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbusy_prog_q <= 1'b0;
    end else if (start && req_data) begin
      dbusy_prog_q <= 1'b1;
    end else if (op_done) begin
      dbusy_prog_q <= 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbusy_erase_q <= 1'b0;
    end else if (start && is_data_area && (req_blk || req_sec)) begin
      dbusy_erase_q <= 1'b1;
    end else if (op_done) begin
      dbusy_erase_q <= 1'b0;
    end
  end

  // ==========================================================
  // read path
  // ==========================================================
  logic [31:0] rdata_d;
  // erase control and unlock read zero
  always_comb begin
    rdata_d = 32'h0;
    case (idx[15:0])
      `FSP_IDX_ADDR: rdata_d = {16'h0, addr_q};
      `FSP_IDX_DATA_LO: rdata_d = {16'h0, data_lo_q};
      `FSP_IDX_DATA_HI: rdata_d = {16'h0, data_hi_q};
      `FSP_IDX_SEGMENT: rdata_d = {27'h0, seg_q};
      `FSP_IDX_SELF: rdata_d = {31'h0, self_en_q};
      `FSP_IDX_STATUS: rdata_d = {30'h0, dbusy_prog_q, dbusy_erase_q};
      default: rdata_d = 32'h0;
    endcase
    if (!in_map) rdata_d = 32'h0;
  end
  // one wait state: answer registered in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= access & ~pready;
      prdata <= (access & ~pready & ~pwrite) ? rdata_d : 32'h0;
      pslverr <= access & ~pready & ~in_map;
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  // arm gone after a start
  chk_arm_cleared: assert property (
    @(posedge pclk) disable iff (!presetn)
    start |=> key_q != fsp_pkg::FSP_KEY_ARMED)
    else $error("arm not cleared after start");
  // no start without enable and arm
  chk_start_gated: assert property (
    @(posedge pclk) disable iff (!presetn)
    op_start |-> $past(self_en_q) && $past(armed))
    else $error("start without enable and arm");
  chk_arm_order: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(armed) |-> $past(key_q) == fsp_pkg::FSP_KEY_HALF)
    else $error("armed without first key");
  // wrong second key drops the half state
  chk_key_drop: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_key && pstrb[0] && !start && key_q == fsp_pkg::FSP_KEY_HALF &&
    pwdata[7:0] != `FSP_KEY_SECOND
    |=> key_q == fsp_pkg::FSP_KEY_IDLE)
    else $error("bad second key kept");
  chk_self_frozen: assert property (
    @(posedge pclk) disable iff (!presetn)
    lsc_q |=> self_en_q == $past(self_en_q))
    else $error("enable changed on slow clock");
  chk_erase_rdzero: assert property (
    @(posedge pclk) disable iff (!presetn)
    access && !pwrite && !pready && idx[15:0] == `FSP_IDX_ERASE
    |=> pready && prdata == 32'h0)
    else $error("erase control read not zero");
  chk_prog_busy: assert property (
    @(posedge pclk) disable iff (!presetn)
    start && req_data
    |=> dbusy_prog_q && op_kind == fsp_pkg::FSP_OP_PROG_DATA)
    else $error("data programming not busy");
  chk_code_align: assert property (
    @(posedge pclk) disable iff (!presetn)
    op_start && op_kind == fsp_pkg::FSP_OP_PROG_CODE
    |-> op_address[1:0] == 2'h0 && cpu_stall)
    else $error("code write not aligned");
  // data erase sets its busy flag
  chk_erase_busy: assert property (
    @(posedge pclk) disable iff (!presetn)
    start && is_data_area && (req_blk || req_sec) |=> dbusy_erase_q)
    else $error("data erase not busy");
  chk_code_stall: assert property (
    @(posedge pclk) disable iff (!presetn)
    start && !is_data_area |=> cpu_stall)
    else $error("code operation did not stall");
  // data operations leave the cpu running
  chk_data_nostall: assert property (
    @(posedge pclk) disable iff (!presetn)
    start && is_data_area |=> !cpu_stall)
    else $error("data operation stalled the cpu");

endmodule : fsp_ctrl

// ===== src/fsp_regs.svh
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH
// byte offsets as printed; some are not multiples of four, so each printed
// offset is an index and the apb byte address is four times it
`define FSP_IDX_ADDR 16'hf090
`define FSP_IDX_DATA_LO 16'hf092
`define FSP_IDX_DATA_HI 16'hf094
`define FSP_IDX_ERASE 16'hf096
`define FSP_IDX_UNLOCK 16'hf098
`define FSP_IDX_SEGMENT 16'hf09a
`define FSP_IDX_SELF 16'hf09c
`define FSP_IDX_STATUS 16'hf09e
// reset values
`define FSP_RST_DATA 16'hffff
`define FSP_RST_ADDR 16'hffff
`define FSP_RST_SEG 5'h10
// segment decode
`define FSP_SEG_DATA_AREA 5'h1f
// erase codes in bits 1..0
`define FSP_ERASE_BLOCK 2'h1
`define FSP_ERASE_SECTOR 2'h2
// unlock key values
`define FSP_KEY_FIRST 8'hfa
`define FSP_KEY_SECOND 8'hf5
// background operation length in pclk cycles
`define FSP_BGO_CYCLES 16'h0040
`endif

// ===== src/fsp_pkg.sv
package fsp_pkg;
  // unlock sequence states
  typedef enum logic [1:0] {
    FSP_KEY_IDLE = 2'b00,
    FSP_KEY_HALF = 2'b01,
    FSP_KEY_ARMED = 2'b10
  } fsp_key_type;
  // flash operation kinds sent to the array engine
  typedef enum logic [2:0] {
    FSP_OP_NONE = 3'b000,
    FSP_OP_PROG_CODE = 3'b001,
    FSP_OP_PROG_DATA = 3'b010,
    FSP_OP_BLOCK_ERASE = 3'b011,
    FSP_OP_SECTOR_ERASE = 3'b100
  } fsp_op_type;
endpackage : fsp_pkg

// ===== verification/fsp_ctrl_tb.sv
`timescale 1ns/1ps
`include "fsp_regs.svh"
// ====================================================================
// scoreboard bench for the self-program front end
module flash_self_program_ctrl_tb_top;
  // expected launch seen at the array side
  typedef struct packed {
    logic [2:0] kind;
    logic [20:0] addr;
    logic [31:0] data;
    logic [31:0] mask;
  } fsp_note_type;
  logic pclk = 1'b0; // 250 mhz
  logic presetn = 1'b0; // async, active low
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [19:0] paddr = 20'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic low_speed_clock = 1'b0;
  logic op_done = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] op_kind;
  logic op_start;
  logic [20:0] op_address;
  logic [31:0] op_data;
  logic cpu_stall;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  int seed = 97;
  logic [32:0] rd_q [$]; // {pslverr, prdata} notes
  fsp_note_type op_q [$]; // launch notes
  logic [32:0] note_r;
  fsp_note_type note_o;
  logic [15:0] dl;
  logic [15:0] dh;
  logic [7:0] db;

  fsp_ctrl dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_speed_clock(low_speed_clock), .op_done(op_done),
    .op_kind(op_kind), .op_start(op_start), .op_address(op_address),
    .op_data(op_data), .cpu_stall(cpu_stall)
  );

  // ====================================================================
  // clock and hang guard
  initial begin
    forever #2 pclk = ~pclk;
  end
  // ceiling well above the few hundred cycles the tests need
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      test_done();
    end
  end

  // ====================================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // setup cycle, then access held until pready is sampled high
  task automatic apb(input logic wr, input logic [15:0] idx,
                     input logic [31:0] wd, input logic [3:0] st);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count is assumed; only the bench ceiling ends a wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd, 4'h3);
  endtask : wr

  // read with the expected answer noted first
  task automatic rd(input logic [15:0] idx, input logic [31:0] exp,
                    input logic err);
    rd_q.push_back({err, exp});
    apb(1'b0, idx, 32'h0, 4'h0);
  endtask : rd

  task automatic note(input logic [2:0] k, input logic [20:0] a,
                      input logic [31:0] d, input logic [31:0] m);
    op_q.push_back('{k, a, d, m});
  endtask : note

  task automatic unlock();
    wr(`FSP_IDX_UNLOCK, 32'hfa);
    wr(`FSP_IDX_UNLOCK, 32'hf5);
  endtask : unlock

  // the array engine reports completion a few cycles later
  task automatic finish_op();
    repeat (4) @(posedge pclk);
    op_done <= 1'b1;
    @(posedge pclk);
    op_done <= 1'b0;
  endtask : finish_op

  task automatic test_done();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  // ====================================================================
  // watcher: oldest note against each answer; stray launches are errors
  always @(posedge pclk) begin
    if (presetn && pready === 1'b1 && !pwrite) begin
      if (rd_q.size() == 0) begin
        chk("stray read", 32'h0, 32'h1);
      end else begin
        note_r = rd_q.pop_front();
        chk("prdata", note_r[31:0], prdata);
        chk("pslverr", {31'h0, note_r[32]}, {31'h0, pslverr});
      end
    end
    if (presetn && op_start === 1'b1) begin
      if (op_q.size() == 0) begin
        chk("stray op_start", 32'h0, 32'h1);
      end else begin
        note_o = op_q.pop_front();
        chk("op_kind", {29'h0, note_o.kind}, {29'h0, op_kind});
        chk("op_address", {11'h0, note_o.addr}, {11'h0, op_address});
        chk("op_data", note_o.data, op_data & note_o.mask);
      end
    end
  end

  // ====================================================================
  // main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`FSP_IDX_DATA_LO, 32'hffff, 1'b0);
    rd(`FSP_IDX_DATA_HI, 32'hffff, 1'b0);
    rd(`FSP_IDX_ERASE, 32'h0, 1'b0);
    rd(`FSP_IDX_SELF, 32'h0, 1'b0);
    rd(`FSP_IDX_STATUS, 32'h0, 1'b0);
    rd(16'hf097, 32'h0, 1'b1);
    $display("test reset values done");
    // armed but not enabled: erase ignored, arm kept for later
    unlock();
    wr(`FSP_IDX_SEGMENT, 32'h3);
    wr(`FSP_IDX_ADDR, 32'h12ab);
    wr(`FSP_IDX_ERASE, 32'h1);
    wr(`FSP_IDX_SELF, 32'h1);
    note(fsp_pkg::FSP_OP_BLOCK_ERASE, {5'h03, 8'h12, 8'h00}, 0, 0);
    wr(`FSP_IDX_ERASE, 32'h1);
    repeat (2) @(posedge pclk);
    chk("cpu_stall", 32'h1, {31'h0, cpu_stall});
    finish_op();
    @(posedge pclk);
    chk("cpu_stall", 32'h0, {31'h0, cpu_stall});
    wr(`FSP_IDX_ERASE, 32'h2);
    unlock();
    wr(`FSP_IDX_ERASE, 32'h0);
    wr(`FSP_IDX_ERASE, 32'h3);
    unlock();
    note(fsp_pkg::FSP_OP_SECTOR_ERASE, {5'h03, 8'h12, 8'h00}, 0, 0);
    wr(`FSP_IDX_ERASE, 32'h2);
    finish_op();
    $display("test erase codes done");
    // code area: four bytes, low register first, address aligned
    dl = 16'($random(seed));
    dh = 16'($random(seed));
    db = 8'($random(seed));
    // target lies inside the sector erased above
    wr(`FSP_IDX_SEGMENT, 32'h3);
    wr(`FSP_IDX_ADDR, 32'h1277);
    unlock();
    wr(`FSP_IDX_DATA_LO, {16'h0, dl});
    note(fsp_pkg::FSP_OP_PROG_CODE, 21'h031274, {dh, dl}, '1);
    wr(`FSP_IDX_DATA_HI, {16'h0, dh});
    finish_op();
    rd(`FSP_IDX_DATA_LO, {16'h0, dl}, 1'b0);
    unlock();
    note(fsp_pkg::FSP_OP_PROG_CODE, 21'h031274,
         {db, dh[7:0], dl}, '1);
    apb(1'b1, `FSP_IDX_DATA_HI, {16'h0, db, 8'h00}, 4'h2);
    finish_op();
    rd(`FSP_IDX_DATA_HI, {16'h0, db, dh[7:0]}, 1'b0);
    $display("test code programming done");
    // data area: only the low byte of the low register launches
    wr(`FSP_IDX_SEGMENT, 32'h1f);
    wr(`FSP_IDX_ADDR, 32'h0042);
    unlock();
    wr(`FSP_IDX_DATA_HI, 32'h1234);
    apb(1'b1, `FSP_IDX_DATA_LO, 32'ha500, 4'h2);
    note(fsp_pkg::FSP_OP_PROG_DATA, 21'h1f0042, {24'h0, db}, 32'hff);
    apb(1'b1, `FSP_IDX_DATA_LO, {24'h0, db}, 4'h1);
    rd(`FSP_IDX_STATUS, 32'h2, 1'b0);
    finish_op();
    rd(`FSP_IDX_STATUS, 32'h0, 1'b0);
    // wrong second key drops the first step
    wr(`FSP_IDX_UNLOCK, 32'hfa);
    wr(`FSP_IDX_UNLOCK, 32'h12);
    wr(`FSP_IDX_UNLOCK, 32'hf5);
    wr(`FSP_IDX_ERASE, 32'h1);
    // a repeated first key is a wrong second key as well
    wr(`FSP_IDX_UNLOCK, 32'hfa);
    wr(`FSP_IDX_UNLOCK, 32'hfa);
    wr(`FSP_IDX_UNLOCK, 32'hf5);
    wr(`FSP_IDX_ERASE, 32'h2);
    // other accesses between the keys keep the sequence
    wr(`FSP_IDX_UNLOCK, 32'hfa);
    rd(`FSP_IDX_STATUS, 32'h0, 1'b0);
    wr(`FSP_IDX_UNLOCK, 32'hf5);
    note(fsp_pkg::FSP_OP_BLOCK_ERASE, {5'h1f, 8'h00, 8'h00}, 0, 0);
    wr(`FSP_IDX_ERASE, 32'h1);
    rd(`FSP_IDX_STATUS, 32'h1, 1'b0);
    finish_op();
    rd(`FSP_IDX_STATUS, 32'h0, 1'b0);
    $display("test data area and keys done");
    // enable holds on the slow clock; synchroniser needs a few cycles
    low_speed_clock <= 1'b1;
    repeat (8) @(posedge pclk);
    wr(`FSP_IDX_SELF, 32'h0);
    rd(`FSP_IDX_SELF, 32'h1, 1'b0);
    low_speed_clock <= 1'b0;
    repeat (8) @(posedge pclk);
    wr(`FSP_IDX_SELF, 32'h0);
    rd(`FSP_IDX_SELF, 32'h0, 1'b0);
    $display("test enable done");
    // a reset in mid-run drops the arm, the enable and the data
    wr(`FSP_IDX_SELF, 32'h1);
    unlock();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`FSP_IDX_SELF, 32'h0, 1'b0);
    rd(`FSP_IDX_DATA_LO, 32'hffff, 1'b0);
    wr(`FSP_IDX_SELF, 32'h1);
    wr(`FSP_IDX_ERASE, 32'h1);
    repeat (10) @(posedge pclk);
    chk("pending launches", 32'h0, 32'(op_q.size()));
    $display("test mid-run reset done");
    test_done();
  end
endmodule : flash_self_program_ctrl_tb_top
